/* File: hdl/sct_params.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef SCT_PARAMS_SVH
`define SCT_PARAMS_SVH

// Device register map
`define SCT_REG_STATUS     8'h00
`define SCT_REG_CTRL       8'h01
`define SCT_REG_DATA       8'h02
`define SCT_REG_FILT_FIRST 8'h21
`define SCT_REG_FILT_LAST  8'h28
`define SCT_FILTER_RESET   24'h060180

// Filter word fields
`define SCT_FS_MSB   10
`define SCT_FS_LSB   0
`define SCT_ZL_BIT   16
`define SCT_TYPE_MSB 23
`define SCT_TYPE_LSB 21

// Device control word fields
`define SCT_CTRL_CH_MSB 2
`define SCT_CTRL_MULTI  3
`define SCT_CTRL_TRIG   4

// Filter timing, in master clock cycles
`define SCT_DECIMATION 32
`define SCT_SINC_ORDER 4
`define SCT_DEAD_FS1   61
`define SCT_DEAD_FSN   95
`define SCT_SYNC_LOW   4

// Host register map
`define SCT_H_CMD    3'h0
`define SCT_H_STATUS 3'h1
`define SCT_H_MASK   3'h2
`define SCT_H_RADDR  3'h3
`define SCT_H_RDATA  3'h4
`define SCT_H_COUNT  3'h5

// Host command and status bits
`define SCT_CMD_SYNC  0
`define SCT_CMD_READ  1
`define SCT_ST_CONV   0
`define SCT_ST_SYNC   1
`define SCT_ST_READ   2

`endif

/* File: hdl/sct_pkg.sv */
// Types shared by both ends of the conversion timing link
package sct_pkg;
	typedef logic [23:0] sct_word_t;
	typedef logic [18:0] sct_count_t;
	typedef enum logic [1:0] {
		SCT_HOLD   = 2'h0,
		SCT_SETTLE = 2'h1,
		SCT_RUN    = 2'h3,
		SCT_IDLE   = 2'h2
	} sct_state_t;
endpackage

/* File: hdl/sct_link_if.sv */
// Pins and register port between host and converter
`timescale 1ns/1ns
`default_nettype none
interface sct_link_if;
	logic            syncN;
	logic            rdyN;
	logic [7:0]      regAddr;
	sct_pkg::sct_word_t regWdata;
	logic            regWrite;
	logic            regRead;
	sct_pkg::sct_word_t regRdata;

	modport device (input syncN, regAddr, regWdata, regWrite, regRead,
		output rdyN, regRdata);
	modport host (output syncN, regAddr, regWdata, regWrite, regRead,
		input rdyN, regRdata);
endinterface
`default_nettype wire

/* File: hdl/sct_device.sv */
// Converter end: sync handling, sinc4 timing, filter setup registers
//
// Behaviour
// (RULE1) Host holds sync low four cycles minimum
// (RULE2) Sync low resets and holds filter, keeps config
// (RULE3) Sampling resumes on first clock after release
// (RULE4) Host releases sync on a rising edge
// (RULE5) Shared clock and sync give simultaneous updates
// (RULE6) Sync rise starts conversion, ready falls when done
// (RULE7) Triggered update takes one full settling time
// (RULE8) Filter type resets to sinc4
// (RULE9) Output period is 32 times rate field
// (RULE10) Rate field unsigned, valid 1 to 2047
// (RULE11) Settling is 128 times field plus dead time
// (RULE12) Channel change restarts, first result after settling
// (RULE13) Single channel keeps converting at programmed rate
// (RULE14) Zero latency makes period 128 times field
// (RULE15) Zero latency first result adds dead time
// (RULE16) Several channels act as zero latency
// (RULE17) Zero latency results each span full settling
// (RULE18) Ready withheld until settling after sync release
//
// The plain strobed port was chosen for this implementation.
`include "sct_params.svh"
`timescale 1ns/1ns
`default_nettype none
module sct_device
	import sct_pkg::*;
#(
	parameter int SETUPS = 8
) (
	// Clock and reset
	input  wire logic   clock,
	input  wire logic   rst_n,
	// Link to host
	sct_link_if.device  link,
	// User side
	output var  logic   running,
	output var  logic [2:0] channel
);
	if (SETUPS != 8) begin : g_check
		$error("sct_device serves exactly eight setups");
	end

	function automatic logic [10:0] fsOf(input sct_word_t cfg);
		// A zero field is outside the legal range and runs as one
		fsOf = (cfg[`SCT_FS_MSB:`SCT_FS_LSB] == 11'h000) ? 11'h001 : cfg[`SCT_FS_MSB:`SCT_FS_LSB]; // [RULE10]
	endfunction

	function automatic sct_count_t deadTime(input logic [10:0] fs);
		deadTime = (fs == 11'h001) ? 19'(`SCT_DEAD_FS1) : 19'(`SCT_DEAD_FSN); // [RULE11] [RULE15]
	endfunction

	function automatic sct_count_t settleCycles(input logic [10:0] fs);
		settleCycles = 19'(fs) * 19'(`SCT_SINC_ORDER * `SCT_DECIMATION) + deadTime(fs); // [RULE11]
	endfunction

	function automatic sct_count_t periodCycles(input logic [10:0] fs, input logic slow);
		periodCycles = 19'(fs) * (slow ? 19'(`SCT_SINC_ORDER * `SCT_DECIMATION)
			: 19'(`SCT_DECIMATION)); // [RULE9] [RULE14]
	endfunction

	sct_word_t   filterCfg [SETUPS];
	logic        multiMode;
	logic        trigMode;
	logic        sync1;
	logic        sync2;
	sct_state_t  state;
	sct_state_t  next_state;
	sct_count_t  count;
	sct_count_t  next_count;
	logic [2:0]  next_channel;
	logic        rdyN;
	logic        next_rdyN;
	logic [20:0] results;
	logic [20:0] next_results;
	sct_word_t   dataReg;
	sct_word_t   next_data;
	sct_word_t   rdata;

	// Register port decode
	wire        filtHit  = link.regAddr >= `SCT_REG_FILT_FIRST && link.regAddr <= `SCT_REG_FILT_LAST;
	wire [2:0]  filtIdx  = 3'(link.regAddr - `SCT_REG_FILT_FIRST);
	wire        ctrlWr   = link.regWrite && link.regAddr == `SCT_REG_CTRL;
	wire [2:0]  newChan  = link.regWdata[`SCT_CTRL_CH_MSB:0];
	wire        chanMove = ctrlWr && newChan != channel;
	wire        active   = state == SCT_SETTLE || state == SCT_RUN;
	wire [2:0]  seqChan  = channel + 3'h1;
	wire [10:0] curFs    = fsOf(filterCfg[channel]);
	wire [10:0] moveFs   = fsOf(filterCfg[newChan]);
	wire [10:0] seqFs    = fsOf(filterCfg[seqChan]);
	wire        slowMode = filterCfg[channel][`SCT_ZL_BIT] || multiMode; // [RULE14] [RULE16]
	wire [7:0]  statusWord = {3'h0, state, rdyN, 2'h0};
	wire [7:0]  ctrlWord = {3'h0, trigMode, multiMode, channel};
	wire        syncLow  = !sync2;

	assign link.rdyN     = rdyN;
	assign link.regRdata = rdata;

	always_comb begin
		next_state   = state;
		next_count   = count;
		next_channel = chanMove ? newChan : channel;
		next_rdyN    = rdyN;
		next_results = results;
		next_data    = dataReg;
		if (syncLow) begin
			// Filter held in reset, setups untouched
			next_state = SCT_HOLD; // [RULE2]
			next_rdyN  = 1'b1;
		end else if (chanMove && active) begin
			next_state = SCT_SETTLE; // [RULE12]
			next_count = settleCycles(moveFs) - 19'h00001; // [RULE15]
			next_rdyN  = 1'b1;
		end else begin
			unique case (state)
				SCT_HOLD: begin
					// Release seen: first result waits a full settling time
					next_state = SCT_SETTLE; // [RULE3] [RULE6]
					next_count = settleCycles(curFs) - 19'h00001; // [RULE7] [RULE18]
				end
				SCT_SETTLE, SCT_RUN: begin
					if (count == 19'h00000) begin
						next_rdyN    = 1'b0; // [RULE6]
						next_results = results + 21'h000001;
						next_data    = {channel, results};
						if (trigMode) begin
							next_state = SCT_IDLE; // [RULE7]
						end else if (multiMode) begin
							next_channel = seqChan;
							next_state   = SCT_SETTLE; // [RULE16]
							next_count   = settleCycles(seqFs) - 19'h00001;
						end else begin
							// Step response is the filter's; the cadence never stops
							next_state = SCT_RUN; // [RULE13] [RULE17]
							next_count = periodCycles(curFs, slowMode) - 19'h00001; // [RULE9]
						end
					end else begin
						// Ready rises one cycle ahead so every result gives a falling edge
						if (count == 19'h00001) begin
							next_rdyN = 1'b1;
						end
						next_count = count - 19'h00001;
					end
				end
				SCT_IDLE: begin
					next_state = SCT_IDLE;
				end
			endcase
		end
	end

	// Pin synchroniser; nothing but sync2 reads sync1
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
		end else begin
			sync1 <= link.syncN;
			sync2 <= sync1;
		end
	end

	// Conversion timing; same cadence in every device on a shared clock
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state   <= SCT_SETTLE;
			count   <= 19'(`SCT_SINC_ORDER * `SCT_DECIMATION * 384 + `SCT_DEAD_FSN - 1);
			channel <= 3'h0;
			rdyN    <= 1'b1;
			results <= 21'h000000;
			dataReg <= 24'h000000;
			running <= 1'b0;
		end else begin
			state   <= next_state; // [RULE5]
			count   <= next_count;
			channel <= next_channel;
			rdyN    <= next_rdyN;
			results <= next_results;
			dataReg <= next_data;
			running <= next_state == SCT_SETTLE || next_state == SCT_RUN;
		end
	end

	// Setup registers survive sync; only the reset pin clears them
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < SETUPS; i++) begin
				filterCfg[i] <= `SCT_FILTER_RESET; // [RULE8]
			end
			multiMode <= 1'b0;
			trigMode  <= 1'b0;
		end else begin
			if (link.regWrite && filtHit) begin
				filterCfg[filtIdx] <= link.regWdata; // [RULE2]
			end
			if (ctrlWr) begin
				multiMode <= link.regWdata[`SCT_CTRL_MULTI];
				trigMode  <= link.regWdata[`SCT_CTRL_TRIG];
			end
		end
	end

	// Read answers one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 24'h000000;
		end else if (link.regRead) begin
			rdata <= filtHit ? filterCfg[filtIdx]
				: link.regAddr == `SCT_REG_STATUS ? {16'h0000, statusWord}
				: link.regAddr == `SCT_REG_CTRL ? {16'h0000, ctrlWord}
				: link.regAddr == `SCT_REG_DATA ? dataReg
				: 24'h000000;
		end
	end
endmodule
`default_nettype wire

/* File: hdl/sct_host.sv */
// Host end: sync pulse generation, remote register access, ready watch
`include "sct_params.svh"
`timescale 1ns/1ns
`default_nettype none
module sct_host
	import sct_pkg::*;
#(
	parameter int SYNC_LOW = `SCT_SYNC_LOW
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Link to converter
	sct_link_if.host         link,
	// Software port
	input  wire logic [2:0]  addr,
	input  wire sct_word_t   wdata,
	input  wire logic        write,
	input  wire logic        read,
	output var  sct_word_t   rdata,
	output var  logic        irq
);
	if (SYNC_LOW < `SCT_SYNC_LOW || SYNC_LOW > 15) begin : g_check
		$error("sct_host sync low length out of range");
	end

	logic [3:0]  syncCnt;
	logic        syncN;
	logic [7:0]  remAddr;
	sct_word_t   remData;
	sct_word_t   remWdata;
	logic        regWrite;
	logic        regRead;
	logic        rdPend;
	logic        rdy1;
	logic        rdy2;
	logic        rdy3;
	logic [2:0]  status;
	logic [2:0]  mask;
	logic [23:0] convCount;

	wire cmdWr     = write && addr == `SCT_H_CMD;
	wire syncStart = cmdWr && wdata[`SCT_CMD_SYNC] && syncCnt == 4'h0;
	wire syncDone  = syncCnt == 4'h1;
	wire convDone  = rdy3 && !rdy2;
	wire [2:0] events = {rdPend, syncDone, convDone};
	wire [2:0] next_status = (read && addr == `SCT_H_STATUS ? 3'h0 : status) | events;

	assign link.syncN    = syncN;
	assign link.regAddr  = remAddr;
	assign link.regWdata = remWdata;
	assign link.regWrite = regWrite;
	assign link.regRead  = regRead;

	// Sync pulse: changed right after a rising edge, low for SYNC_LOW cycles
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			syncN   <= 1'b1;
			syncCnt <= 4'h0;
		end else if (syncStart) begin
			syncN   <= 1'b0; // [RULE1]
			syncCnt <= 4'(SYNC_LOW);
		end else if (syncCnt != 4'h0) begin
			syncCnt <= syncCnt - 4'h1;
			if (syncDone) begin
				syncN <= 1'b1; // [RULE4] [RULE5]
			end
		end
	end

	// Ready pin synchroniser and falling edge detect
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdy1 <= 1'b1;
			rdy2 <= 1'b1;
			rdy3 <= 1'b1;
		end else begin
			rdy1 <= link.rdyN;
			rdy2 <= rdy1;
			rdy3 <= rdy2;
		end
	end

	// Remote register access, one strobe per software command
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			remAddr  <= 8'h00;
			remWdata <= 24'h000000;
			remData  <= 24'h000000;
			regWrite <= 1'b0;
			regRead  <= 1'b0;
			rdPend   <= 1'b0;
		end else begin
			regWrite <= write && addr == `SCT_H_RDATA; // [RULE10]
			regRead  <= cmdWr && wdata[`SCT_CMD_READ];
			rdPend   <= regRead;
			if (write && addr == `SCT_H_RADDR) begin
				remAddr <= wdata[7:0];
			end
			if (write && addr == `SCT_H_RDATA) begin
				remWdata <= wdata;
			end
			if (rdPend) begin
				remData <= link.regRdata;
			end
		end
	end

	// Sticky status: an event in the clearing read's cycle still sets
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			status    <= 3'h0;
			mask      <= 3'h0;
			irq       <= 1'b0;
			convCount <= 24'h000000;
		end else begin
			status <= next_status;
			irq    <= |(next_status & (write && addr == `SCT_H_MASK ? wdata[2:0] : mask));
			if (write && addr == `SCT_H_MASK) begin
				mask <= wdata[2:0];
			end
			if (convDone) begin
				convCount <= convCount + 24'h000001; // [RULE6]
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 24'h000000;
		end else if (read) begin
			rdata <= addr == `SCT_H_CMD ? {23'h000000, syncCnt != 4'h0}
				: addr == `SCT_H_STATUS ? {21'h000000, status}
				: addr == `SCT_H_MASK ? {21'h000000, mask}
				: addr == `SCT_H_RADDR ? {16'h0000, remAddr}
				: addr == `SCT_H_RDATA ? remData
				: addr == `SCT_H_COUNT ? convCount
				: 24'h000000;
		end else begin
			rdata <= 24'h000000;
		end
	end
endmodule
`default_nettype wire

/* File: testbench/sct_link_properties.sv */
// Timing checks on the sync and ready pins between host and converter
`timescale 1ns/1ns
`default_nettype none
module sct_link_properties (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Link pins
	input wire logic syncN,
	input wire logic rdyN
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// Saturating counters stand in for long repetitions
	logic       prevRdy;
	logic [9:0] sinceFall;
	logic [9:0] sinceSync;
	wire        fallNow = prevRdy && !rdyN;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prevRdy <= 1'b1;
			sinceFall <= 10'h000;
			sinceSync <= 10'h000;
		end else begin
			prevRdy <= rdyN;
			sinceFall <= fallNow ? 10'h000 : sinceFall + {9'h000, sinceFall != 10'h3FF};
			sinceSync <= !syncN ? 10'h000 : sinceSync + {9'h000, sinceSync != 10'h3FF};
		end
	end
	sequence syncLow4;
		!syncN [*4];
	endsequence
	sequence syncPulse;
		syncLow4 ##1 syncN;
	endsequence
	a_sync_low_min: assert property ($fell(syncN) |-> syncLow4)
		else $error("sync pulse shorter than four cycles");
	a_sync_pulse_len: assert property ($fell(syncN) |-> syncPulse)
		else $error("sync pulse length differs from four cycles");
	a_ready_on_sync: assert property ($fell(syncN) |-> ##[1:3] rdyN)
		else $error("ready not raised after sync fall");
	a_hold_ready: assert property (syncLow4 |=> rdyN)
		else $error("ready low while held in sync");
	a_settle_quiet: assert property ($rose(syncN) |-> rdyN [*8])
		else $error("ready fell right after sync release");
	a_release_clean: assert property ($rose(syncN) |-> syncN [*8])
		else $error("sync dropped again right after release");
	a_period_floor: assert property (fallNow |-> sinceFall >= 10'd31)
		else $error("results closer than the shortest period");
	// A result already due while the pin's fall sits in the device synchroniser is legal
	a_settle_floor: assert property (fallNow && syncN |-> sinceSync >= 10'h0BD)
		else $error("result before shortest settling time");
endmodule
`default_nettype wire

/* File: testbench/test_sinc4_conversion_timing_sync.sv */
// Self-checking bench for host and converter joined by the link
`include "sct_params.svh"
`timescale 1ns/1ns
`default_nettype none
module test_sinc4_conversion_timing_sync;
	import sct_pkg::*;
	logic       clock;
	logic       rst_n;
	logic [2:0] addr;
	sct_word_t  wdata;
	logic       write;
	logic       read;
	sct_word_t  rdata;
	logic       irq;
	logic       running;
	logic [2:0] channel;
	int         failures;
	int         total_checks;
	int         n;
	sct_word_t  v;
	sct_link_if link();
	sct_device sct_device_inst(.clock(clock), .rst_n(rst_n), .link(link),
		.running(running), .channel(channel));
	sct_host sct_host_inst(.clock(clock), .rst_n(rst_n), .link(link), .addr(addr),
		.wdata(wdata), .write(write), .read(read), .rdata(rdata), .irq(irq));
	sct_link_properties sct_link_properties_inst(.clock(clock), .rst_n(rst_n),
		.syncN(link.syncN), .rdyN(link.rdyN));
	always #20 clock = ~clock;
	task automatic check(string what, sct_word_t seen, sct_word_t exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		if (failures == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic swWrite(logic [2:0] a, sct_word_t d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		write <= 1'b1;
		@(posedge clock);
		write <= 1'b0;
	endtask
	task automatic swRead(logic [2:0] a, output sct_word_t d);
		@(posedge clock);
		addr <= a;
		read <= 1'b1;
		@(posedge clock);
		read <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic devWrite(logic [7:0] a, sct_word_t d);
		swWrite(`SCT_H_RADDR, {16'h0000, a});
		swWrite(`SCT_H_RDATA, d);
		repeat (2) @(posedge clock);
	endtask
	task automatic devRead(logic [7:0] a, output sct_word_t d);
		swWrite(`SCT_H_RADDR, {16'h0000, a});
		swWrite(`SCT_H_CMD, 24'h000002);
		repeat (4) @(posedge clock);
		swRead(`SCT_H_RDATA, d);
	endtask
	// Counts edges up to the next ready fall, bounded by limit
	task automatic waitFall(int limit, output int k);
		logic p;
		k = 0;
		do begin
			p = link.rdyN;
			@(posedge clock);
			#1;
			k++;
		end while (k <= limit && !(p === 1'b1 && link.rdyN === 1'b0));
	endtask
	// Sync and write paths add a few cycles of their own
	task automatic settle(string what, int s);
		waitFall(60000, n);
		check(what, 24'(n >= s - 2 && n <= s + 12), 24'h000001);
	endtask
	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		addr = 3'h0;
		wdata = 24'h000000;
		write = 1'b0;
		read = 1'b0;
		failures = 0;
		total_checks = 0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		check("irq", {23'h000000, irq}, 24'h000000);
		swRead(`SCT_H_STATUS, v);
		check("status", v, 24'h000000);
		swRead(3'h7, v);
		check("unmapped", v, 24'h000000);
		devRead(`SCT_REG_FILT_LAST, v);
		check("setup7", v, `SCT_FILTER_RESET);
		swRead(`SCT_H_RADDR, v);
		check("raddr", v, 24'h000028);
		devWrite(`SCT_REG_FILT_FIRST, 24'h060001);
		devRead(`SCT_REG_FILT_FIRST, v);
		check("setup0", v, 24'h060001);
		swRead(`SCT_H_STATUS, v);
		swWrite(`SCT_H_MASK, 24'h000001);
		swWrite(`SCT_H_CMD, 24'h000001);
		repeat (5) @(posedge clock);
		#1;
		check("running", {23'h000000, running}, 24'h000000);
		settle("settle_sync", 189);
		waitFall(60000, n);
		check("period", 24'(n), 24'h000020);
		check("irq_set", {23'h000000, irq}, 24'h000001);
		swRead(`SCT_H_STATUS, v);
		check("status_ready", v & 24'h000001, 24'h000001);
		// The last fall is still in the synchroniser, so look right after the clearing read
		check("irq_clear", {23'h000000, irq}, 24'h000000);
		devRead(`SCT_REG_FILT_FIRST, v);
		check("setup0_kept", v, 24'h060001);
		devWrite(`SCT_REG_FILT_FIRST, 24'h070001);
		swWrite(`SCT_H_CMD, 24'h000001);
		// A result may still fall before the device sees the pin go low
		repeat (5) @(posedge clock);
		settle("settle_zl", 189);
		waitFall(60000, n);
		check("period_zl", 24'(n), 24'h000080);
		devWrite(8'h22, 24'h060002);
		devWrite(`SCT_REG_CTRL, 24'h000001);
		settle("settle_chan", 351);
		waitFall(60000, n);
		check("period_chan", 24'(n), 24'h000040);
		check("channel", {21'h000000, channel}, 24'h000001);
		check("running_on", {23'h000000, running}, 24'h000001);
		devRead(`SCT_REG_CTRL, v);
		check("ctrl", v, 24'h000001);
		devWrite(`SCT_REG_CTRL, 24'h000008);
		settle("settle_multi", 189);
		waitFall(60000, n);
		check("period_multi", 24'(n), 24'h00015F);
		check("channel_seq", {21'h000000, channel}, 24'h000002);
		devWrite(`SCT_REG_CTRL, 24'h000010);
		swWrite(`SCT_H_CMD, 24'h000001);
		repeat (5) @(posedge clock);
		settle("settle_trig", 189);
		waitFall(400, n);
		check("trig_idle", 24'(n > 400), 24'h000001);
		close_out();
	end
	// Tests run some two thousand two hundred cycles; this allows over twenty times that
	initial begin
		#2000000;
		failures++;
		close_out();
	end
endmodule
`default_nettype wire
